// >>> sysctl_pkg.sv
// Package with the constants, types and state layout of the system-control pin block.
package sysctl_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam int CTRL_WIDTH = 6;
  localparam int STAT_CAUSE = 2;
  localparam int STAT_IRQ = 3;
  localparam int STAT_NONMASKABLE_INTERRUPT_PIN = 4;
  localparam int STAT_INRST = 5;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam logic [1:0] E_LAST_PHASE = 2'h3;
  localparam logic [1:0] E_PHASE_PRE_HIGH = 2'h1;
  localparam logic [3:0] RELEASE_LIMIT_E = 4'h2;
  localparam int DRIVE_E_DEFAULT = 4;

  typedef enum logic [1:0] {
    MODE_BOOT = 2'b00,
    MODE_TEST = 2'b01,
    MODE_SINGLE = 2'b10,
    MODE_EXPANDED = 2'b11
  } mode_e;

  typedef enum logic [1:0] {
    RS_RUN = 2'b00,
    RS_DRIVE = 2'b01,
    RS_WAIT = 2'b10,
    RS_EXT = 2'b11
  } rst_e;

  typedef struct packed {
    logic stop;
    logic imask;
    logic xmask;
    logic e_off;
    logic edge_sel;
    logic quad_en;
  } ctrl_s;

  localparam ctrl_s CTRL_RST = '{stop: 1'b0, imask: 1'b1, xmask: 1'b1, e_off: 1'b0, edge_sel: 1'b0, quad_en: 1'b1};

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    rst_e fsm;
    logic [3:0] cnt;
    logic cause_int;
    mode_e mode;
    ctrl_s ctrl;
    logic [1:0] phase;
    logic osc_prev;
    logic irq_prev;
    logic edge_pend;
    logic e;
    logic quad;
    logic reset_oe;
    logic reset_out;
    logic lir_oe;
    logic lir_out;
    logic irq_req;
    logic nonmaskable_interrupt_pin_req;
    logic ack;
    logic [31:0] dat;
  } state_s;

  localparam state_s STATE_RST = '{fsm: RS_EXT, cnt: 4'h0, cause_int: 1'b0, mode: MODE_BOOT, ctrl: CTRL_RST,
    phase: 2'h0, osc_prev: 1'b0, irq_prev: 1'b1, edge_pend: 1'b0, e: 1'b0, quad: 1'b0, reset_oe: 1'b0,
    reset_out: 1'b0, lir_oe: 1'b0, lir_out: 1'b0, irq_req: 1'b0, nonmaskable_interrupt_pin_req: 1'b0, ack: 1'b0, dat: 32'h0000_0000};

  function automatic logic single_chip(input mode_e m);
    return (m == MODE_BOOT) || (m == MODE_SINGLE);
  endfunction

endpackage

// >>> sysctl_pins.sv
// System-control pin logic: reset pin, bus-phase and quad clocks, interrupt pins, mode pins, instruction strobe.
//
// Contract
// - Low reset pin initialises all logic; here only control, pending edge, requests and strobe enable.
// - Clock or watchdog failure pulls reset pin low.
// - Pin high within two bus cycles: internal.
// - Bus-phase clock is oscillator divided by four.
// - Bus-phase clock low processing, high accessing.
// - Stop mode halts every clock output.
// - Single-chip modes may switch bus clock off.
// - Quad clock enabled at reset, cleared bit stops.
// - Edge-select bit picks falling edge or low level.
// - Maskable pin is level-sensitive after reset.
// - Reset sets nonmaskable mask; requests ignored meanwhile.
// - Held-low level line retaken when mask clears.
// - Mode pins choose one of four modes.
// - Strobe pulls low during each opcode fetch cycle.
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
module sysctl_pins #(
  parameter int DRIVE_E_CYCLES = sysctl_pkg::DRIVE_E_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sysctl_pkg::wb_req_s wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic osc_input_i,
  input wire logic reset_n_i,
  output logic reset_o,
  output logic reset_oe_o,
  input wire logic clock_fail_i,
  input wire logic liveness_watchdog_fail_i,
  output logic e_clock_o,
  output logic quad_rate_clock_out_o,
  input wire logic irq_n_i,
  input wire logic irq_ack_i,
  output logic irq_req_o,
  input wire logic nonmaskable_interrupt_pin_n_i,
  output logic nonmaskable_interrupt_pin_req_o,
  input wire logic mode_select_a_i,
  input wire logic mode_select_b_i,
  output logic [1:0] mode_o,
  input wire logic opcode_fetch_i,
  output logic instr_start_strobe_o,
  output logic instr_start_strobe_oe_o
);
  import sysctl_pkg::*;

  // The drive counter is four bits wide, which bounds how long the pin can be held.
  if (DRIVE_E_CYCLES < 1 || DRIVE_E_CYCLES > 15) begin
    $error("DRIVE_E_CYCLES must lie between 1 and 15");
  end

  localparam logic [3:0] DRIVE_LAST = 4'(DRIVE_E_CYCLES - 1);

  state_s st_r;
  state_s st_nxt;

  logic osc_rise;
  logic e_start;
  logic failure;
  logic running;
  logic bus_req;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    running = (st_r.fsm == RS_RUN);
    failure = clock_fail_i | liveness_watchdog_fail_i;
    osc_rise = osc_input_i & ~st_r.osc_prev & ~st_r.ctrl.stop;
    e_start = osc_rise && (st_r.phase == E_LAST_PHASE);
    bus_req = wb_i.cyc & wb_i.stb & ~st_r.ack;
    st_nxt.osc_prev = osc_input_i;
    st_nxt.irq_prev = irq_n_i;

    // Clocks: the divider stands still while stopped, so the bus clock resumes in the phase where it stopped.
    if (osc_rise) begin
      st_nxt.phase = st_r.phase + 2'h1;
    end
    st_nxt.e = st_nxt.phase[1] & ~st_r.ctrl.stop & ~(st_r.ctrl.e_off & single_chip(st_r.mode));
    st_nxt.quad = osc_input_i & st_r.ctrl.quad_en & ~st_r.ctrl.stop;

    // Reset pin sequencing.
    unique case (st_r.fsm)
      RS_RUN: begin
        if (failure) begin
          st_nxt.fsm = RS_DRIVE;
          st_nxt.reset_oe = 1'b1;
          st_nxt.cnt = 4'h0;
        end else if (!reset_n_i) begin
          st_nxt.fsm = RS_EXT;
        end
      end
      RS_DRIVE: begin
        if (e_start) begin
          st_nxt.cnt = st_r.cnt + 4'h1;
          if (st_r.cnt == DRIVE_LAST) begin
            st_nxt.fsm = RS_WAIT;
            st_nxt.reset_oe = 1'b0;
            st_nxt.cnt = 4'h0;
          end
        end
      end
      RS_WAIT: begin
        if (reset_n_i) begin
          st_nxt.fsm = RS_RUN;
          st_nxt.cause_int = 1'b1;
        end else if (e_start) begin
          st_nxt.cnt = st_r.cnt + 4'h1;
          if (st_r.cnt == RELEASE_LIMIT_E - 4'h1) begin
            st_nxt.fsm = RS_EXT;
          end
        end
      end
      RS_EXT: begin
        if (reset_n_i) begin
          st_nxt.fsm = RS_RUN;
          st_nxt.cause_int = 1'b0;
        end
      end
    endcase

    // The mode pins are caught only on the release edge, so later pin changes cannot move the mode.
    if (!running && st_nxt.fsm == RS_RUN) begin
      st_nxt.mode = mode_e'({mode_select_b_i, mode_select_a_i});
    end

    // Interrupt pins.
    if (st_r.ctrl.edge_sel && st_r.irq_prev && !irq_n_i) begin
      st_nxt.edge_pend = 1'b1;
    end else if (irq_ack_i) begin
      st_nxt.edge_pend = 1'b0;
    end
    st_nxt.irq_req = running & ~st_r.ctrl.imask
      & (st_r.ctrl.edge_sel ? st_r.edge_pend : ~irq_n_i);
    st_nxt.nonmaskable_interrupt_pin_req = running & ~st_r.ctrl.xmask & ~nonmaskable_interrupt_pin_n_i;

    // Instruction strobe is sampled once per bus cycle, at the start of its low phase.
    if (e_start) begin
      st_nxt.lir_oe = opcode_fetch_i & running;
    end

    // Register bus: answer one cycle after the request, then drop for a cycle.
    st_nxt.ack = bus_req;
    if (bus_req) begin
      st_nxt.dat = 32'h0000_0000;
      if (wb_i.adr == ADDR_CTRL) begin
        st_nxt.dat[CTRL_WIDTH-1:0] = st_r.ctrl;
        if (wb_i.we && wb_i.sel[0] && running) begin
          st_nxt.ctrl.quad_en = wb_i.dat[0];
          st_nxt.ctrl.edge_sel = wb_i.dat[1];
          st_nxt.ctrl.e_off = wb_i.dat[2];
          st_nxt.ctrl.xmask = st_r.ctrl.xmask & wb_i.dat[3];
          st_nxt.ctrl.imask = wb_i.dat[4];
          st_nxt.ctrl.stop = wb_i.dat[5];
        end
      end else if (wb_i.adr == ADDR_STAT) begin
        st_nxt.dat[1:0] = st_r.mode;
        st_nxt.dat[STAT_CAUSE] = st_r.cause_int;
        st_nxt.dat[STAT_IRQ] = st_r.irq_req;
        st_nxt.dat[STAT_NONMASKABLE_INTERRUPT_PIN] = st_r.nonmaskable_interrupt_pin_req;
        st_nxt.dat[STAT_INRST] = ~running;
      end
    end

    // A low pin wakes the device out of stop; it follows the write so that the pin wins over it.
    if (!irq_n_i || !nonmaskable_interrupt_pin_n_i) begin
      st_nxt.ctrl.stop = 1'b0;
    end

    // While the reset pin is low the control register, pending edge, interrupt requests and strobe enable return to their start-up values.
    if (st_nxt.fsm != RS_RUN) begin
      st_nxt.ctrl = CTRL_RST;
      st_nxt.edge_pend = 1'b0;
      st_nxt.irq_req = 1'b0;
      st_nxt.nonmaskable_interrupt_pin_req = 1'b0;
      st_nxt.lir_oe = 1'b0;
    end
    st_nxt.reset_out = 1'b0;
    st_nxt.lir_out = 1'b0;
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = st_r.dat;
  assign wb_ack_o = st_r.ack;
  assign reset_o = st_r.reset_out;
  assign reset_oe_o = st_r.reset_oe;
  assign e_clock_o = st_r.e;
  assign quad_rate_clock_out_o = st_r.quad;
  assign irq_req_o = st_r.irq_req;
  assign nonmaskable_interrupt_pin_req_o = st_r.nonmaskable_interrupt_pin_req;
  assign mode_o = st_r.mode;
  assign instr_start_strobe_o = st_r.lir_out;
  assign instr_start_strobe_oe_o = st_r.lir_oe;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ext_reset;
    (st_r.fsm == RS_RUN) && !reset_n_i && !failure |=> (st_r.fsm == RS_EXT) && (st_r.ctrl == CTRL_RST);
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("external reset not taken");

  property p_fail_drive;
    (st_r.fsm == RS_RUN) && failure |=> reset_oe_o && !reset_o;
  endproperty
  a_fail_drive: assert property (p_fail_drive) else $error("reset pin not driven on failure");

  property p_cause;
    (st_r.fsm == RS_WAIT) && reset_n_i |=> st_r.cause_int && (st_r.fsm == RS_RUN);
  endproperty
  a_cause: assert property (p_cause) else $error("internal reset cause not recorded");

  property p_e_rise;
    osc_rise && (st_r.phase == E_PHASE_PRE_HIGH) && !(st_r.ctrl.e_off && single_chip(st_r.mode)) |=> e_clock_o;
  endproperty
  a_e_rise: assert property (p_e_rise) else $error("bus clock missed its high phase");

  property p_stop;
    st_r.ctrl.stop |=> !e_clock_o && !quad_rate_clock_out_o;
  endproperty
  a_stop: assert property (p_stop) else $error("clock running in stop");

  property p_e_off;
    st_r.ctrl.e_off && single_chip(st_r.mode) |=> !e_clock_o;
  endproperty
  a_e_off: assert property (p_e_off) else $error("bus clock not switched off");

  property p_quad_off;
    !st_r.ctrl.quad_en |=> !quad_rate_clock_out_o;
  endproperty
  a_quad_off: assert property (p_quad_off) else $error("quad clock runs while disabled");

  property p_irq_level;
    running && !st_r.ctrl.edge_sel && !st_r.ctrl.imask && !irq_n_i && (st_nxt.fsm == RS_RUN) |=> irq_req_o;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("level interrupt not requested");

  property p_xmask;
    (st_r.fsm != RS_RUN) |-> st_r.ctrl.xmask && !nonmaskable_interrupt_pin_req_o && !st_r.ctrl.edge_sel;
  endproperty
  a_xmask: assert property (p_xmask) else $error("masks wrong during reset");

  property p_mode_hold;
    running ##1 running |-> $stable(mode_o);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed outside reset");

  property p_lir;
    e_start && opcode_fetch_i && running && (st_nxt.fsm == RS_RUN) |=> instr_start_strobe_oe_o && !instr_start_strobe_o;
  endproperty
  a_lir: assert property (p_lir) else $error("instruction strobe missing");

  property p_wait_timeout;
    (st_r.fsm == RS_WAIT) && !reset_n_i && e_start && (st_r.cnt == RELEASE_LIMIT_E - 4'h1) |=> st_r.fsm == RS_EXT;
  endproperty
  a_wait_timeout: assert property (p_wait_timeout) else $error("late release not taken as external");

  property p_ext_cause;
    (st_r.fsm == RS_EXT) && reset_n_i |=> running && !st_r.cause_int;
  endproperty
  a_ext_cause: assert property (p_ext_cause) else $error("external reset cause not recorded");

  property p_drive_len;
    (st_r.fsm == RS_DRIVE) && !(e_start && (st_r.cnt == DRIVE_LAST)) |=> reset_oe_o;
  endproperty
  a_drive_len: assert property (p_drive_len) else $error("reset pin released early");

  property p_e_low;
    osc_rise && (st_r.phase == E_LAST_PHASE) |=> !e_clock_o;
  endproperty
  a_e_low: assert property (p_e_low) else $error("bus clock missed its low phase");

  property p_quad_follow;
    st_r.ctrl.quad_en && !st_r.ctrl.stop |=> quad_rate_clock_out_o == $past(osc_input_i);
  endproperty
  a_quad_follow: assert property (p_quad_follow) else $error("quad clock does not follow the oscillator");

  property p_irq_edge;
    running && st_r.ctrl.edge_sel && !st_r.ctrl.imask && st_r.edge_pend && (st_nxt.fsm == RS_RUN) |=> irq_req_o;
  endproperty
  a_irq_edge: assert property (p_irq_edge) else $error("edge interrupt not requested");

  property p_irq_no_level;
    st_r.ctrl.edge_sel && !st_r.edge_pend |=> !irq_req_o;
  endproperty
  a_irq_no_level: assert property (p_irq_no_level) else $error("level taken in edge mode");

  property p_nonmaskable_interrupt_pin;
    running && !st_r.ctrl.xmask && !nonmaskable_interrupt_pin_n_i && (st_nxt.fsm == RS_RUN) |=> nonmaskable_interrupt_pin_req_o;
  endproperty
  a_nonmaskable_interrupt_pin: assert property (p_nonmaskable_interrupt_pin) else $error("nonmaskable request missing");

  property p_mode_latch;
    !running && (st_nxt.fsm == RS_RUN) |=> mode_o == $past({mode_select_b_i, mode_select_a_i});
  endproperty
  a_mode_latch: assert property (p_mode_latch) else $error("mode pins not latched at release");

  property p_lir_hold;
    running && !e_start && (st_nxt.fsm == RS_RUN) |=> $stable(instr_start_strobe_oe_o);
  endproperty
  a_lir_hold: assert property (p_lir_hold) else $error("strobe changed inside a bus cycle");

endmodule

// >>> sysctl_far_side.sv
// Far-side model: free oscillator, pulled-up reset line and two open-drain interrupt sources.
module sysctl_far_side (
  input wire logic clk_i,
  input wire logic reset_oe_i,
  input wire logic ext_reset_i,
  input wire logic [1:0] raise_i,
  input wire logic [1:0] src_ack_i,
  output logic osc_o,
  output logic reset_n_o,
  output logic irq_n_o,
  output logic nonmaskable_interrupt_pin_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Sources
  // ------------------------------------------------------------
  logic [1:0] div_r = 2'h0;
  logic [1:0] pend_r = 2'h0;
  // A source keeps its line low until it is acknowledged, so a late service still sees it.
  always_ff @(posedge clk_i) begin
    div_r <= div_r + 2'h1;
    pend_r <= (pend_r | raise_i) & ~src_ack_i;
  end
  assign osc_o = div_r[1];
  // Both parties only pull the reset line low; the pull-up gives the high level.
  assign reset_n_o = !(reset_oe_i || ext_reset_i);
  assign irq_n_o = !pend_r[0];
  assign nonmaskable_interrupt_pin_n_o = !pend_r[1];
endmodule

// >>> tb.sv
// Self-checking bench for the system-control pin block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sysctl_pkg::*;
  // ------------------------------------------------------------
  // Signals, instances and tasks
  // ------------------------------------------------------------
  logic clk_i, rst_i, cfail, wdog, iack, fetch, ext_rst, mode_a, mode_b;
  logic [1:0] raise, sack, mode;
  wb_req_s wb;
  logic [31:0] dat, rd;
  logic ack, rst_o, rst_oe, e_clk, quad, irq_req, nonmaskable_interrupt_pin_req, instr_start_strobe, lir_oe, osc, rst_n, irq_n, nonmaskable_interrupt_pin_n;
  int err_total = 0;
  int n_compared = 0;
  int er, eh, qr, lh, n;
  sysctl_pins #(.DRIVE_E_CYCLES(1)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(dat), .wb_ack_o(ack),
    .osc_input_i(osc), .reset_n_i(rst_n), .reset_o(rst_o), .reset_oe_o(rst_oe), .clock_fail_i(cfail),
    .liveness_watchdog_fail_i(wdog), .e_clock_o(e_clk), .quad_rate_clock_out_o(quad), .irq_n_i(irq_n),
    .irq_ack_i(iack), .irq_req_o(irq_req), .nonmaskable_interrupt_pin_n_i(nonmaskable_interrupt_pin_n), .nonmaskable_interrupt_pin_req_o(nonmaskable_interrupt_pin_req),
    .mode_select_a_i(mode_a), .mode_select_b_i(mode_b), .mode_o(mode), .opcode_fetch_i(fetch),
    .instr_start_strobe_o(instr_start_strobe), .instr_start_strobe_oe_o(lir_oe));
  sysctl_far_side far (.clk_i(clk_i), .reset_oe_i(rst_oe), .ext_reset_i(ext_rst), .raise_i(raise),
    .src_ack_i(sack), .osc_o(osc), .reset_n_o(rst_n), .irq_n_o(irq_n), .nonmaskable_interrupt_pin_n_o(nonmaskable_interrupt_pin_n));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // The master waits for ack with no assumed latency; only the watchdog ends a hang.
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = dat;
    wb <= '0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check(nm, rd, exp);
  endtask
  task automatic src(input logic [1:0] r, input logic [1:0] a);
    raise <= r;
    sack <= a;
    @(posedge clk_i);
    raise <= 2'h0;
    sack <= 2'h0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic pulse_ack();
    iack <= 1'b1;
    @(posedge clk_i);
    iack <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  // Counts clock rises and high cycles over 32 samples, two whole bus cycles.
  task automatic window();
    logic pe;
    logic pq;
    {er, eh, qr, lh} = '0;
    repeat (32) begin
      pe = e_clk;
      pq = quad;
      @(posedge clk_i);
      er += int'(e_clk === 1'b1 && pe === 1'b0);
      qr += int'(quad === 1'b1 && pq === 1'b0);
      eh += int'(e_clk === 1'b1);
      lh += int'(lir_oe === 1'b1);
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #100us;
    err_total++;
    report_and_stop();
  end
  initial begin
    {rst_i, cfail, wdog, iack, fetch, ext_rst, mode_a, mode_b} <= 8'h89;
    raise <= 2'h0;
    sack <= 2'h0;
    wb <= '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    mode_a <= 1'b1;
    mode_b <= 1'b0;
    rdc("ctrl", ADDR_CTRL, 32'h19);
    rdc("stat", ADDR_STAT, 32'h02);
    check("mode", 32'(mode), 32'h2);
    rdc("unmapped", 8'h08, 32'h0);
    src(2'b10, 2'b00);
    check("nonmaskable_interrupt_pin masked", 32'(nonmaskable_interrupt_pin_req), 32'h0);
    xfer(1'b1, ADDR_CTRL, 32'h11);
    repeat (3) @(posedge clk_i);
    check("nonmaskable_interrupt_pin", 32'(nonmaskable_interrupt_pin_req), 32'h1);
    xfer(1'b1, ADDR_CTRL, 32'h19);
    rdc("xmask", ADDR_CTRL, 32'h11);
    src(2'b00, 2'b10);
    window();
    check("e rises", er, 2);
    check("e high", eh, 16);
    check("quad rises", qr, 8);
    check("strobe", lh, 32);
    fetch <= 1'b0;
    xfer(1'b1, ADDR_CTRL, 32'h15);
    repeat (20) @(posedge clk_i);
    window();
    check("e off", er, 0);
    check("quad on", qr, 8);
    check("strobe off", lh, 0);
    xfer(1'b1, ADDR_CTRL, 32'h10);
    window();
    check("quad off", qr, 0);
    check("e on", er, 2);
    xfer(1'b1, ADDR_CTRL, 32'h21);
    window();
    check("stop e", er, 0);
    check("stop quad", qr, 0);
    src(2'b01, 2'b00);
    check("irq level", 32'(irq_req), 32'h1);
    rdc("woken", ADDR_CTRL, 32'h01);
    pulse_ack();
    check("irq held", 32'(irq_req), 32'h1);
    src(2'b00, 2'b01);
    check("irq gone", 32'(irq_req), 32'h0);
    xfer(1'b1, ADDR_CTRL, 32'h11);
    src(2'b01, 2'b00);
    check("irq masked", 32'(irq_req), 32'h0);
    xfer(1'b1, ADDR_CTRL, 32'h01);
    repeat (2) @(posedge clk_i);
    check("irq again", 32'(irq_req), 32'h1);
    src(2'b00, 2'b01);
    xfer(1'b1, ADDR_CTRL, 32'h03);
    src(2'b01, 2'b00);
    check("irq edge", 32'(irq_req), 32'h1);
    pulse_ack();
    check("edge clear", 32'(irq_req), 32'h0);
    src(2'b00, 2'b01);
    mode_a <= 1'b1;
    mode_b <= 1'b1;
    wdog <= 1'b1;
    @(posedge clk_i);
    wdog <= 1'b0;
    for (n = 0; n < 100 && rst_oe !== 1'b1; n++) @(posedge clk_i);
    check("reset drive", 32'(rst_oe), 32'h1);
    check("reset level", 32'(rst_o), 32'h0);
    for (n = 0; n < 100 && rst_oe !== 1'b0; n++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    rdc("internal", ADDR_STAT, 32'h07);
    mode_a <= 1'b1;
    mode_b <= 1'b0;
    rdc("ctrl init", ADDR_CTRL, 32'h19);
    check("mode kept", 32'(mode), 32'h3);
    xfer(1'b1, ADDR_CTRL, 32'h05);
    window();
    check("e expanded", er, 2);
    ext_rst <= 1'b1;
    repeat (40) @(posedge clk_i);
    xfer(1'b0, ADDR_STAT, 32'h0);
    check("in reset", rd & 32'h20, 32'h20);
    ext_rst <= 1'b0;
    repeat (3) @(posedge clk_i);
    rdc("external", ADDR_STAT, 32'h01);
    mode_a <= 1'b0;
    mode_b <= 1'b0;
    ext_rst <= 1'b1;
    wdog <= 1'b1;
    @(posedge clk_i);
    wdog <= 1'b0;
    repeat (80) @(posedge clk_i);
    ext_rst <= 1'b0;
    repeat (3) @(posedge clk_i);
    rdc("late release", ADDR_STAT, 32'h00);
    xfer(1'b1, ADDR_CTRL, 32'h05);
    window();
    check("e boot off", er, 0);
    check("strobe level", 32'(instr_start_strobe), 32'h0);
    report_and_stop();
  end
endmodule
